// ==== rtl/ops_pkg.sv ====
// Shared constants and types for the output pin function select block.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package ops_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_REGS = 6;
  localparam int NUM_PINS = 12;
  localparam int FIRST_PIN = 64;
  localparam int FIELD_W = 6;
  localparam int REG_W = 16;
  localparam int NUM_FUNCS = 64;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ==========================================================
  // Field positions inside each selection register
  localparam int EVEN_LSB = 0;
  localparam int ODD_LSB = 8;
  localparam int EVEN_STRB = 0;
  localparam int ODD_STRB = 1;

  // ==========================================================
  // Codes and reset values
  localparam logic [FIELD_W-1:0] FUNC_NONE = 6'h00;
  localparam logic [FIELD_W-1:0] SEL_RESET = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFF_PINS_64_65 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PINS_66_67 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PINS_68_69 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PINS_70_71 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PINS_72_73 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PINS_74_75 = 8'h14;
  localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFFSETS = {
    OFF_PINS_74_75, OFF_PINS_72_73, OFF_PINS_70_71,
    OFF_PINS_68_69, OFF_PINS_66_67, OFF_PINS_64_65
  };

  // ==========================================================
  // Types
  typedef logic [FIELD_W-1:0] ops_field_type;

  // One pin's drive: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } ops_pin_type;

  // Whole state of the top module
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [NUM_REGS-1:0][1:0][FIELD_W-1:0] sel;
  } ops_state_type;

  localparam ops_state_type STATE_RESET = '0;

endpackage

// ==== rtl/ops_addr_decode.sv ====
// Address decoder for the selection registers.
// Assumes the address comes from logic on the same clock.
`timescale 1ns/10ps
module ops_addr_decode
  import ops_pkg::*;
(
  // Address in
  input wire logic [ADDR_W-1:0] i_addr,
  // Decode result
  output logic o_hit,
  output logic [IDX_W-1:0] o_index
);

  // Low address bits are ignored so any byte of a word selects it
  always_comb begin
    o_hit = 1'b0;
    o_index = '0;
    for (int r = 0; r < NUM_REGS; r++) begin
      if (i_addr[ADDR_W-1:2] == REG_OFFSETS[r][ADDR_W-1:2]) begin
        o_hit = 1'b1;
        o_index = IDX_W'(r);
      end
    end
  end

endmodule

// ==== rtl/ops_pin_route.sv ====
// Routing mux for one remappable output pin.
// Assumes peripheral and port drives come from logic on the same clock.
`timescale 1ns/10ps
module ops_pin_route
  import ops_pkg::*;
(
  // Selection field of this pin
  input wire ops_field_type i_sel,
  // Candidate drives
  input wire ops_pin_type [NUM_FUNCS-1:0] i_periph,
  input wire ops_pin_type i_port,
  // Drive to the pad
  output ops_pin_type o_pin,
  output logic o_remapped
);

  // Kept combinational so peripheral timing reaches the pad unchanged
  always_comb begin
    if (i_sel == FUNC_NONE) begin
      o_pin = i_port;
      o_remapped = 1'b0;
    end else begin
      o_pin = i_periph[i_sel];
      o_remapped = 1'b1;
    end
  end

endmodule

// ==== rtl/ops_top.sv ====
// Output pin function select: six 16-bit selection registers on AXI4-Lite,
// each steering two of the remappable output pins 64 to 75.
// Assumes an AXI4-Lite master on i_clk and peripheral drives on i_clk.
//
// Notes on behaviour
// - Bits 13:8 select odd pin function
// - Bits 5:0 select even pin function
// - Six-bit field routes numbered peripheral output; code 0 routes the pin's port drive instead
// - Bits 15:14, 7:6 read zero, ignore writes
// - Reset clears every selection field
// - Fields read back last written value
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module ops_top
  import ops_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Peripheral outputs, indexed by function number
  input wire ops_pin_type [NUM_FUNCS-1:0] i_periph,
  // Ordinary port drive per pin, index 0 is pin 64
  input wire ops_pin_type [NUM_PINS-1:0] i_port,
  // Pad drive per pin, index 0 is pin 64
  output ops_pin_type [NUM_PINS-1:0] o_pin,
  output logic [NUM_PINS-1:0] o_remapped
);

  // ==========================================================
  // State
  ops_state_type state;
  ops_state_type next_state;
  logic wr_hit;
  logic [IDX_W-1:0] wr_index;
  logic rd_hit;
  logic [IDX_W-1:0] rd_index;
  logic [REG_W-1:0] rd_word;
  logic commit;

  // Protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // ==========================================================
  // Address decode
  // Write decode looks at the held address, read decode at the live one
  ops_addr_decode u_wr_decode (
    .i_addr(state.aw_addr),
    .o_hit(wr_hit),
    .o_index(wr_index)
  );

  ops_addr_decode u_rd_decode (
    .i_addr(s_axi_araddr),
    .o_hit(rd_hit),
    .o_index(rd_index)
  );

  // ==========================================================
  // Handshake outputs
  // Address and data are taken in either order; each side holds one
  assign s_axi_awready = !state.aw_held;
  assign s_axi_wready = !state.w_held;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;

  // A write commits once both halves are held and no response waits
  assign commit = state.aw_held && state.w_held && !state.bvalid;

  // Read word: unimplemented bits stay zero whatever was written
  always_comb begin
    rd_word = '0;
    rd_word[ODD_LSB +: FIELD_W] = state.sel[rd_index][1];
    rd_word[EVEN_LSB +: FIELD_W] = state.sel[rd_index][0];
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    // Capture write address
    if (s_axi_awvalid && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    // Capture write data
    if (s_axi_wvalid && !state.w_held) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    // Retire a taken write response
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    // Commit the write; only the field bits are stored
    if (commit) begin
      if (wr_hit) begin
        if (state.w_strb[ODD_STRB]) begin
          next_state.sel[wr_index][1] = state.w_data[ODD_LSB +: FIELD_W];
        end
        if (state.w_strb[EVEN_STRB]) begin
          next_state.sel[wr_index][0] = state.w_data[EVEN_LSB +: FIELD_W];
        end
        next_state.bresp = RESP_OKAY;
      end else begin
        next_state.bresp = RESP_SLVERR;
      end
      next_state.bvalid = 1'b1;
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
    end
    // Retire a taken read response
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    // Accept a read; an unmapped word answers zero with an error
    if (s_axi_arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      if (rd_hit) begin
        next_state.rdata = {{(DATA_W-REG_W){1'b0}}, rd_word};
        next_state.rresp = RESP_OKAY;
      end else begin
        next_state.rdata = '0;
        next_state.rresp = RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Pin routing, one mux per pin; pin pair r holds pins 2r and 2r+1
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    ops_pin_route u_route (
      .i_sel(state.sel[p / 2][p % 2]),
      .i_periph(i_periph),
      .i_port(i_port[p]),
      .o_pin(o_pin[p]),
      .o_remapped(o_remapped[p])
    );
  end

endmodule

// ==== dv/ops_checker.sv ====
// Checker for the pin select block: bus answers and pin routing.
// Bound to ops_top, sees only its ports, one clock domain.
`timescale 1ns/10ps
module ops_checker
  import ops_pkg::*;
(
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  // Pins
  input wire ops_pin_type [NUM_PINS-1:0] i_port,
  input wire ops_pin_type [NUM_PINS-1:0] o_pin,
  input wire logic [NUM_PINS-1:0] o_remapped
);
  // ==========
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Both halves of a write taken on one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_resp;
    ##[1:8] s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> s_wr_resp)
    else $error("write got no response");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read got no data");
  chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_unused_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:14] == '0 && s_axi_rdata[7:6] == '0) else $error("unused bits set");
  // Reset is checked even while it is asserted
  chk_reset_clear: assert property (disable iff (1'h0) i_rst |=>
    o_remapped == '0 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset left state");
  chk_zero_port: assert property (!o_remapped[0] |-> o_pin[0] == i_port[0])
    else $error("pin 64 not under port");
  chk_zero_last: assert property (!o_remapped[11] |-> o_pin[11] == i_port[11])
    else $error("pin 75 not under port");
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the pin select block over AXI4-Lite.
// Assumes the checker file is compiled alongside; the bench is the bus master.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench
  import ops_pkg::*;
;
  typedef struct {logic [31:0] wd; logic [15:0] ex;} ops_row_type;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [STRB_W-1:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  ops_pin_type [NUM_FUNCS-1:0] i_periph;
  ops_pin_type [NUM_PINS-1:0] i_port = '0, o_pin;
  logic [NUM_PINS-1:0] o_remapped;
  ops_field_type f;
  logic [2:0] ep;
  int errors = 0, check_count = 0;
  // Upper bits set in rows 0 and 5 must read back as zero
  ops_row_type rows [NUM_REGS] = '{'{32'hFFFF_FFFF, 16'h3F3F}, '{32'h0000_1503, 16'h1503},
    '{32'h0000_2A01, 16'h2A01}, '{32'h0000_0102, 16'h0102},
    '{32'h0000_3E00, 16'h3E00}, '{32'h0000_C0C6, 16'h0006}};
  ops_top ops_top_i (.*);
  // ==========
  // Clock, reset, peripheral drives
  always #10 i_clk = ~i_clk;
  // Entry 0 differs from the port drive so a wrong route of code 0 shows
  initial for (int k = 0; k < NUM_FUNCS; k++) i_periph[k] = (k == 0) ? 2'h3 : 2'(k);
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'h0;
  end
  // ==========
  // Bus tasks; the response is taken late so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge i_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    do begin
      @(posedge i_clk);
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!(ta && tw));
    repeat (2) @(posedge i_clk);
    s_axi_bready <= 1'h1;
    do @(posedge i_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    do @(posedge i_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge i_clk);
    s_axi_rready <= 1'h1;
    do @(posedge i_clk); while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========
  // Table walk, then strobes, unmapped word, port drive and reset
  initial begin
    wait (i_rst == 1'h0);
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(REG_OFFSETS[i]);
      `CHK(rdv, 32'h0)
      wr(REG_OFFSETS[i], rows[i].wd, 4'hF);
      `CHK(resp, RESP_OKAY)
      rd(REG_OFFSETS[i]);
      `CHK(rdv, {16'h0, rows[i].ex})
      for (int j = 0; j < 2; j++) begin
        f = rows[i].ex[8*j +: 6];
        ep = {f != 6'h0, (f == 6'h0) ? 2'h0 : f[1:0]};
        `CHK({o_remapped[2*i+j], o_pin[2*i+j]}, ep)
      end
    end
    wr(OFF_PINS_66_67, 32'h0000_2222, 4'h2);
    rd(OFF_PINS_66_67);
    `CHK(rdv, 32'h0000_2203)
    // Low strobe alone must leave the odd field as it was
    wr(OFF_PINS_66_67, 32'h0000_3F05, 4'h1);
    `CHK(resp, RESP_OKAY)
    rd(OFF_PINS_66_67);
    `CHK(rdv, 32'h0000_2205)
    `CHK({o_remapped[2], o_pin[2]}, 3'h5)
    wr(8'h18, 32'hFFFF_FFFF, 4'hF);
    `CHK(resp, RESP_SLVERR)
    rd(8'h18);
    `CHK({resp, rdv}, {RESP_SLVERR, 32'h0})
    @(posedge i_clk);
    i_port <= {NUM_PINS{2'h2}};
    @(posedge i_clk);
    `CHK(o_pin[8], 2'h2)
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    `CHK({o_remapped, o_pin}, {12'h0, {NUM_PINS{2'h2}}})
    rd(OFF_PINS_64_65);
    `CHK(rdv, 32'h0)
    conclude();
  end
  // Whole run needs a few microseconds
  initial begin
    #50us;
    errors++;
    conclude();
  end
endmodule
bind ops_top ops_checker ops_checker_i (.*);
